//--- verilog/auto_wake_unit.sv
// stop-mode periodic wakeup generator with its keyboard interrupt registers
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

`include "auto_wake_map.svh"

module auto_wake_unit #(
  parameter int SHORT_PERIOD = `SHORT_PERIOD,
  parameter int LONG_PERIOD = `LONG_PERIOD
) (
  input wire logic clock,
  input wire logic rst,
  input wire auto_wake_pkg::reg_req_type bus,
  output logic [7:0] rdata,
  input wire logic stop_mode,
  input wire logic wait_mode,
  input wire logic wakeup_rc_osc,
  input wire logic double_bus_clock,
  output logic wakeup_request_input,
  output logic wakeup_latch,
  output logic kbd_irq,
  output logic stop_wake,
  output logic rc_osc_enable,
  output logic bus_clk_stop_enable
);

  import auto_wake_pkg::*;

  localparam int CNT_W = $clog2(LONG_PERIOD);

  mode_type mode;
  mode_type next_mode;
  logic active;
  logic rc_tick;
  logic bus_tick;
  logic tick;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] last_count;
  logic period_select;
  logic osc_run_in_stop;
  logic config_one_done;
  logic config_two_done;
  logic wakeup_irq_enable;
  logic kbd_irq_mask;
  logic kbd_ack;
  logic [5:0] port_a_bits;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic is_write(reg_req_type r, logic [7:0] a);
    return r.wr && (r.addr == a);
  endfunction

  function automatic logic [CNT_W-1:0] terminal(logic short_sel);
    if (short_sel) begin
      return CNT_W'(SHORT_PERIOD - 1);
    end
    return CNT_W'(LONG_PERIOD - 1);
  endfunction

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_comb begin
    next_mode = MODE_RUN;
    if (wait_mode) begin
      next_mode = MODE_WAIT;
    end else if (stop_mode) begin
      next_mode = MODE_STOP;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode <= MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // wait mode leaves the unit as idle as normal run
  always_comb begin
    unique case (mode)
      MODE_RUN: active = 1'b0;
      MODE_WAIT: active = 1'b0;
      MODE_STOP: active = 1'b1;
      default: active = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  pin_rise_sync rc_sync (
    .clock(clock),
    .rst(rst),
    .pin(wakeup_rc_osc),
    .rise(rc_tick)
  );

  pin_rise_sync bus_sync (
    .clock(clock),
    .rst(rst),
    .pin(double_bus_clock),
    .rise(bus_tick)
  );

  assign tick = osc_run_in_stop ? bus_tick : rc_tick;
  assign last_count = terminal(period_select);

  // sources only run in stop; the rc one only when the bus clock is off
  always_ff @(posedge clock) begin
    if (rst) begin
      rc_osc_enable <= 1'b0;
      bus_clk_stop_enable <= 1'b0;
    end else begin
      rc_osc_enable <= active && !osc_run_in_stop;
      bus_clk_stop_enable <= active && osc_run_in_stop;
    end
  end

  // ----------------------------------------------------------------
  // request generator
  // ----------------------------------------------------------------
  // held at zero outside stop, so each entry starts afresh
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      counter <= '0;
    end else if (tick) begin
      if (counter >= last_count) begin
        counter <= '0;
      end else begin
        counter <= counter + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wakeup_request_input <= 1'b0;
    end else begin
      wakeup_request_input <= active && tick && (counter >= last_count);
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // written once after each reset; later writes are dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      period_select <= `PERIOD_SEL_RESET;
      config_one_done <= 1'b0;
    end else if (is_write(bus, `CONFIG_ONE_ADDR) && !config_one_done) begin
      period_select <= bus.wdata[`PERIOD_SEL_BIT];
      config_one_done <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      osc_run_in_stop <= `OSC_STOP_RESET;
      config_two_done <= 1'b0;
    end else if (is_write(bus, `CONFIG_TWO_ADDR) && !config_two_done) begin
      osc_run_in_stop <= bus.wdata[`OSC_STOP_BIT];
      config_two_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // keyboard interrupt registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      wakeup_irq_enable <= `IRQ_EN_RESET;
    end else if (is_write(bus, `KBD_IER_ADDR)) begin
      wakeup_irq_enable <= bus.wdata[`IRQ_EN_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      kbd_irq_mask <= `MASK_RESET;
    end else if (is_write(bus, `KBD_SCR_ADDR)) begin
      kbd_irq_mask <= bus.wdata[`MASK_BIT];
    end
  end

  assign kbd_ack = is_write(bus, `KBD_SCR_ADDR) && bus.wdata[`ACK_BIT];

  // port pins live elsewhere; only their data latches are kept here
  always_ff @(posedge clock) begin
    if (rst) begin
      port_a_bits <= 6'h00;
    end else if (is_write(bus, `PORT_A_ADDR)) begin
      port_a_bits <= bus.wdata[5:0];
    end
  end

  // ----------------------------------------------------------------
  // wakeup latch
  // ----------------------------------------------------------------
  // a request in the acknowledge cycle wins, so none is lost
  always_ff @(posedge clock) begin
    if (rst) begin
      wakeup_latch <= 1'b0;
    end else if (wakeup_request_input && wakeup_irq_enable) begin
      wakeup_latch <= 1'b1;
    end else if (kbd_ack) begin
      wakeup_latch <= 1'b0;
    end
  end

  // shared keyboard vector request and stop exit
  always_ff @(posedge clock) begin
    if (rst) begin
      kbd_irq <= 1'b0;
      stop_wake <= 1'b0;
    end else begin
      kbd_irq <= wakeup_latch && !kbd_irq_mask;
      stop_wake <= wakeup_latch && !kbd_irq_mask && active;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `PORT_A_ADDR: rdata <= {1'b0, wakeup_latch, port_a_bits};
        `KBD_SCR_ADDR: rdata <= {4'h0, wakeup_latch, 1'b0,
                                 kbd_irq_mask, 1'b0};
        `KBD_IER_ADDR: rdata <= {1'b0, wakeup_irq_enable, 6'h00};
        `CONFIG_ONE_ADDR: rdata <= {period_select, 7'h00};
        `CONFIG_TWO_ADDR: rdata <= {6'h00, osc_run_in_stop, 1'b0};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence seq_overflow;
    active && tick && (counter == last_count);
  endsequence

  sequence seq_enabled_request;
    wakeup_request_input && wakeup_irq_enable;
  endsequence

  property prop_wrap;
    seq_overflow ##1 active |-> counter == '0;
  endproperty

  property prop_latch_set;
    seq_enabled_request |=> wakeup_latch ##1 kbd_irq || kbd_irq_mask;
  endproperty

  AST_IDLE_RUN: assert property (
    mode == MODE_RUN |=> counter == '0 && !wakeup_request_input)
    else $error("counter moved outside stop mode");

  AST_RESTART: assert property (
    $rose(active) |-> counter == '0)
    else $error("counter not zero on stop entry");

  AST_WAIT_QUIET: assert property (
    mode == MODE_WAIT |=> !wakeup_request_input && counter == '0)
    else $error("activity during wait mode");

  AST_BUS_SOURCE: assert property (
    (active && osc_run_in_stop && !bus_tick) ##1 active |-> $stable(counter))
    else $error("counter stepped without a bus clock tick");

  AST_RC_SOURCE: assert property (
    (active && !osc_run_in_stop && !rc_tick) ##1 active |-> $stable(counter))
    else $error("counter stepped without an rc tick");

  AST_OVERFLOW: assert property (
    seq_overflow |=> wakeup_request_input)
    else $error("overflow gave no request");

  AST_LATCH_SET: assert property (prop_latch_set)
    else $error("enabled request not latched");

  AST_ENABLE_GATE: assert property (
    wakeup_request_input && !wakeup_irq_enable && !wakeup_latch
      |=> !wakeup_latch)
    else $error("latch set while disabled");

  AST_SHARED_VECTOR: assert property (
    kbd_irq |-> $past(wakeup_latch))
    else $error("interrupt without a latched request");

  AST_PERIOD_SELECT: assert property (
    period_select |-> last_count == CNT_W'(SHORT_PERIOD - 1))
    else $error("short period not selected");

  AST_LONG_PERIOD: assert property (
    !period_select |-> last_count == CNT_W'(LONG_PERIOD - 1))
    else $error("long period not selected");

  AST_READ_LATCH: assert property (
    bus.rd && bus.addr == `PORT_A_ADDR
      |=> rdata[`LATCH_BIT] == $past(wakeup_latch) && !rdata[7])
    else $error("latch bit read wrong");

  AST_ENABLE_NO_EFFECT: assert property (
    bus.rd && bus.addr == `PORT_A_ADDR && !wakeup_irq_enable
      && wakeup_latch |=> rdata[`LATCH_BIT])
    else $error("enable hid the latch value");

  AST_ACK_CLEAR: assert property (
    kbd_ack && !(wakeup_request_input && wakeup_irq_enable)
      |=> !wakeup_latch ##1 !kbd_irq)
    else $error("acknowledge did not clear the latch");

  AST_ACK_READS_ZERO: assert property (
    bus.rd && bus.addr == `KBD_SCR_ADDR |=> !rdata[`ACK_BIT])
    else $error("acknowledge bit read back high");

  AST_MASK: assert property (
    kbd_irq_mask |=> !stop_wake && !kbd_irq)
    else $error("masked request left stop mode");

  AST_WRAP: assert property (prop_wrap)
    else $error("counter did not wrap to zero");

endmodule // auto_wake_unit

`default_nettype wire

//--- shared/auto_wake_map.svh
// register offsets, field positions, reset values and counts of the wakeup unit
`ifndef AUTO_WAKE_MAP_SVH
`define AUTO_WAKE_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PORT_A_ADDR 8'h00
`define KBD_SCR_ADDR 8'h1a
`define KBD_IER_ADDR 8'h1b
`define CONFIG_TWO_ADDR 8'h1e
`define CONFIG_ONE_ADDR 8'h1f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define LATCH_BIT 6
`define KEYF_BIT 3
`define ACK_BIT 2
`define MASK_BIT 1
`define IRQ_EN_BIT 6
`define PERIOD_SEL_BIT 7
`define OSC_STOP_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PERIOD_SEL_RESET 1'b0
`define OSC_STOP_RESET 1'b0
`define IRQ_EN_RESET 1'b0
`define MASK_RESET 1'b0

// ----------------------------------------------------------------
// wakeup periods, in wakeup clock cycles
// ----------------------------------------------------------------
`define SHORT_PERIOD 512
`define LONG_PERIOD 16384

`endif

//--- shared/auto_wake_pkg.sv
// types shared by the wakeup unit files
package auto_wake_pkg;

  // ----------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // ----------------------------------------------------------------
  // operating mode of the microcontroller
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_WAIT = 2'b01,
    MODE_STOP = 2'b10
  } mode_type;

endpackage

//--- verilog/pin_rise_sync.sv
// three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none

module pin_rise_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  output logic rise
);

  logic stage_one;
  logic stage_two;
  logic stage_three;
  logic level;

  // ----------------------------------------------------------------
  // synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_three <= 1'b0;
    end else begin
      stage_one <= pin;
      stage_two <= stage_one;
      stage_three <= stage_two;
    end
  end

  // ----------------------------------------------------------------
  // accepted level and edge
  // ----------------------------------------------------------------
  // a change counts only once the last two stages agree
  always_ff @(posedge clock) begin
    if (rst) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      rise <= (stage_two == stage_three) && stage_three && !level;
      if (stage_two == stage_three) begin
        level <= stage_three;
      end
    end
  end

endmodule // pin_rise_sync

`default_nettype wire

//--- testbench/wake_osc_model.sv
// far-side model: wakeup clock sources gated by the stop-mode enables
`timescale 1ns/1ps
`default_nettype none

module wake_osc_model (
  input wire logic rc_en,
  input wire logic bus_en,
  output logic rc_pin,
  output logic bus_pin,
  output logic [15:0] ticks
);
  logic [15:0] edges = 16'h0000;
  logic [15:0] base = 16'h0000;

  // ----------------------------------------------------------------
  // sources run only while enabled, park low otherwise
  // ----------------------------------------------------------------
  // half periods differ so the two sources never share a phase;
  // the 5 ns offset keeps pin edges off the clock edges, so no race
  initial begin
    rc_pin = 1'b0;
    #5;
    forever begin
      #110;
      rc_pin = rc_en ? ~rc_pin : 1'b0;
    end
  end

  initial begin
    bus_pin = 1'b0;
    #5;
    forever begin
      #130;
      bus_pin = bus_en ? ~bus_pin : 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // tick count since the last entry into stop
  // ----------------------------------------------------------------
  always @(posedge rc_pin or posedge bus_pin) edges = edges + 16'h0001;
  always @(posedge rc_en or posedge bus_en) base = edges;
  assign ticks = edges - base;
endmodule // wake_osc_model

`default_nettype wire

//--- testbench/auto_wake_unit_tb_top.sv
// self-checking bench for the stop-mode wakeup unit
`timescale 1ns/1ps
`default_nettype none

`include "auto_wake_map.svh"

module auto_wake_unit_tb_top;
  import auto_wake_pkg::*;

  // short counts keep the run brief
  localparam int SHORT = 4;
  localparam int LONG = 16;

  logic clock, rst, stop_mode, wait_mode, rc_pin, bus_pin;
  logic req, latch, kbd_irq, stop_wake, rc_en, bus_en;
  logic psel, osc, en, mask, seen;
  logic [7:0] rdata, d;
  logic [15:0] ticks;
  reg_req_type bus;
  int miscompares, cmp_count, per, k;
  logic [2:0] exp_irq;
  // rows: {period select, run-in-stop, irq enable, mask,
  //        expected latch, expected irq, expected stop exit}
  logic [6:0] rows [4] = '{7'b1010111, 7'b0111100, 7'b1100000,
                           7'b0010111};

  auto_wake_unit #(.SHORT_PERIOD(SHORT), .LONG_PERIOD(LONG)) i_dut (
    .clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .stop_mode(stop_mode), .wait_mode(wait_mode),
    .wakeup_rc_osc(rc_pin), .double_bus_clock(bus_pin),
    .wakeup_request_input(req), .wakeup_latch(latch),
    .kbd_irq(kbd_irq), .stop_wake(stop_wake),
    .rc_osc_enable(rc_en), .bus_clk_stop_enable(bus_en)
  );

  wake_osc_model i_osc (
    .rc_en(rc_en), .bus_en(bus_en), .rc_pin(rc_pin),
    .bus_pin(bus_pin), .ticks(ticks)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen_v,
                       input logic [7:0] exp_v);
    cmp_count++;
    if (seen_v !== exp_v) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen_v);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock) bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock) bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) bus <= '0;
    #1 v = rdata;
  endtask

  task automatic pulse_reset();
    @(posedge clock) rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic wait_req();
    int n;
    n = 0;
    while (req !== 1'b1) begin
      if (n == 2000) begin
        miscompares++;
        end_sim();
      end
      n++;
      @(negedge clock);
    end
  endtask

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    stop_mode = 1'b0;
    wait_mode = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    // config registers take one write per reset, so each row resets
    for (int i = 0; i < 4; i++) begin
      {psel, osc, en, mask, exp_irq} = rows[i];
      per = psel ? SHORT : LONG;
      pulse_reset();
      reg_wr(`CONFIG_ONE_ADDR, {psel, 7'h00});
      reg_wr(`CONFIG_TWO_ADDR, {6'h00, osc, 1'b0});
      reg_wr(`KBD_IER_ADDR, {1'b0, en, 6'h00});
      reg_wr(`KBD_SCR_ADDR, {6'h00, mask, 1'b0});
      @(posedge clock) stop_mode <= 1'b1;
      wait_req();
      check("ticks first", ticks[7:0], 8'(per));
      check("source", {6'h00, rc_en, bus_en}, {6'h00, ~osc, osc});
      repeat (3) @(negedge clock);
      check("irq", {5'h00, latch, kbd_irq, stop_wake},
            {5'h00, exp_irq});
      reg_rd(`PORT_A_ADDR, d);
      check("latch bit", d & 8'h40, {1'b0, en, 6'h00});
      wait_req();
      check("ticks second", ticks[7:0], 8'(2 * per));
      @(posedge clock) stop_mode <= 1'b0;
      repeat (3) @(negedge clock);
      check("run idle", {6'h00, rc_en, bus_en}, 8'h00);
      reg_wr(`KBD_SCR_ADDR, {5'h00, 1'b1, mask, 1'b0});
      repeat (2) @(negedge clock);
      check("ack latch", {7'h00, latch}, 8'h00);
      reg_rd(`KBD_SCR_ADDR, d);
      check("scr", d, {6'h00, mask, 1'b0});
    end

    // ----------------------------------------------------------------
    // restart on re-entry, enable vs read, reset, map
    // ----------------------------------------------------------------
    @(posedge clock) stop_mode <= 1'b1;
    for (k = 0; k < 500 && ticks < 16'h0003; k++) @(negedge clock);
    if (k == 500) begin
      miscompares++;
      end_sim();
    end
    @(posedge clock) stop_mode <= 1'b0;
    repeat (20) @(posedge clock);
    stop_mode <= 1'b1;
    wait_req();
    check("ticks restart", ticks[7:0], 8'(LONG));
    repeat (3) @(negedge clock);
    reg_wr(`KBD_IER_ADDR, 8'h00);
    reg_rd(`PORT_A_ADDR, d);
    check("latch no enable", d & 8'h40, 8'h40);
    @(posedge clock) stop_mode <= 1'b0;
    pulse_reset();
    @(negedge clock);
    check("reset latch", {6'h00, latch, kbd_irq}, 8'h00);
    reg_wr(`PORT_A_ADDR, 8'hff);
    reg_rd(`PORT_A_ADDR, d);
    check("port a", d, 8'h3f);
    reg_rd(8'h55, d);
    check("unmapped", d, 8'h00);

    // wait mode wins over stop: nothing runs
    reg_wr(`KBD_IER_ADDR, 8'h40);
    @(posedge clock) begin
      stop_mode <= 1'b1;
      wait_mode <= 1'b1;
    end
    seen = 1'b0;
    repeat (400) begin
      @(negedge clock);
      seen = seen | req | latch | rc_en | bus_en;
    end
    check("wait idle", {7'h00, seen}, 8'h00);
    end_sim();
  end
endmodule // auto_wake_unit_tb_top

`default_nettype wire
